/* rtl/ccso_top.sv */
// Completion stream output stage: FIFO, packet gating and masked output register
//
// Notes on behaviour
// - Valid is high in every cycle that meaningful completion data is presented.
// - Once a packet starts with its end queued, valid stays high until its last beat is accepted.
// - A beat moves only when valid and ready are high together.
// - While ready is low and valid high, data and sideband hold and valid stays.
// - Sideband low 32 bits mark which data bytes carry payload.
// - Byte-valid bits stay low on lanes holding descriptor content.
// - Set byte-valid bits form one contiguous run within a packet's payload.
// - At 128-bit width, byte-valid bits 31 to 16 are always zero.
// - At 64-bit width, byte-valid bits 31 to 8 are always zero.
// - Last-beat output is high on each packet's final beat, single beats too.
// - Unused upper data bits are zero at 128-bit and 64-bit widths.
// - Dword keep is contiguous; only a packet's final beat may be partial.
`timescale 1ns/1ps
`include "ccso_cfg.svh"
module ccso_top
    import ccso_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    input  wire logic [1:0]                 bus_width_in,
    input  wire logic                       src_valid_in,
    output logic                            src_ready_out,
    input  wire logic [`CCSO_DATA_W-1:0]    src_data_in,
    input  wire logic                       src_last_in,
    input  wire logic [`CCSO_DWCNT_W-1:0]   src_dw_count_in,
    input  wire logic                       src_pay_en_in,
    input  wire logic [`CCSO_LANE_W-1:0]    src_pay_lo_in,
    input  wire logic [`CCSO_LANE_W-1:0]    src_pay_hi_in,
    output logic                            cpl_out_valid,
    input  wire logic [`CCSO_READY_W-1:0]   cpl_out_ready,
    output logic [`CCSO_DATA_W-1:0]         cpl_out_data,
    output logic [`CCSO_SIDE_W-1:0]         cpl_out_sideband,
    output logic                            cpl_out_last_beat,
    output logic [`CCSO_KEEP_W-1:0]         cpl_out_dword_keep
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Bytes the configured width carries
    function automatic logic [5:0] width_bytes(input ccso_width_t w);
        logic [5:0] n;
        n = `CCSO_BYTES_256;
        unique case (w)
            CCSO_W64:  n = `CCSO_BYTES_64;
            CCSO_W128: n = `CCSO_BYTES_128;
            CCSO_W256: n = `CCSO_BYTES_256;
            default:   n = `CCSO_BYTES_256;
        endcase
        return n;
    endfunction : width_bytes

    // Dwords the configured width carries
    function automatic logic [`CCSO_DWCNT_W-1:0] width_dwords(input ccso_width_t w);
        logic [`CCSO_DWCNT_W-1:0] n;
        n = `CCSO_DWORDS_256;
        unique case (w)
            CCSO_W64:  n = `CCSO_DWORDS_64;
            CCSO_W128: n = `CCSO_DWORDS_128;
            CCSO_W256: n = `CCSO_DWORDS_256;
            default:   n = `CCSO_DWORDS_256;
        endcase
        return n;
    endfunction : width_dwords

    // Ones in the low n positions of a byte-lane mask
    function automatic logic [`CCSO_BE_W-1:0] low_bytes(input logic [5:0] n);
        logic [`CCSO_BE_W-1:0] m;
        m = '0;
        for (int i = 0; i < `CCSO_BE_W; i++) begin
            m[i] = (6'(i) < n);
        end
        return m;
    endfunction : low_bytes

    // Ones in the low n positions of a dword mask
    function automatic logic [`CCSO_KEEP_W-1:0] low_dwords(input logic [`CCSO_DWCNT_W-1:0] n);
        logic [`CCSO_KEEP_W-1:0] m;
        m = '0;
        for (int i = 0; i < `CCSO_KEEP_W; i++) begin
            m[i] = (`CCSO_DWCNT_W'(i) < n);
        end
        return m;
    endfunction : low_dwords

    ////////////////////////////////////////////////////////////////////////
    // Width strap: a pin, so two flops before use

    logic [1:0]  width_meta_reg;
    logic [1:0]  width_sync_reg;
    ccso_width_t width_cfg;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            width_meta_reg <= CCSO_W256;
            width_sync_reg <= CCSO_W256;
        end else begin
            width_meta_reg <= bus_width_in;
            width_sync_reg <= width_meta_reg;
        end
    end

    // Code 2'b11 falls back to the widest bus
    always_comb begin
        width_cfg = (width_sync_reg == 2'h3) ? CCSO_W256 : ccso_width_t'(width_sync_reg);
    end

    ////////////////////////////////////////////////////////////////////////
    // Beat FIFO

    ccso_entry_t fifo_in;
    ccso_entry_t fifo_out;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_pop;

    always_comb begin
        fifo_in.last     = src_last_in;
        fifo_in.dw_count = src_dw_count_in;
        fifo_in.pay_en   = src_pay_en_in;
        fifo_in.pay_lo   = src_pay_lo_in;
        fifo_in.pay_hi   = src_pay_hi_in;
        fifo_in.data     = src_data_in;
        src_ready_out    = fifo_in_ready;
    end

    ccso_fifo #(
        .WIDTH ($bits(ccso_entry_t)),
        .DEPTH (`CCSO_FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (src_valid_in),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Packet gating: a packet starts only when its end is already queued,
    // or the FIFO is full, so a slow source can open a gap in valid only in a packet longer than the FIFO.

    logic [`CCSO_LASTCNT_W-1:0] lasts_reg;
    logic [`CCSO_LASTCNT_W-1:0] lasts_next;
    logic                       in_pkt_reg;
    logic                       in_pkt_next;
    logic                       push_last;
    logic                       pop_last;
    logic                       may_release;

    // Output register state
    logic                       valid_reg;
    logic                       valid_next;
    logic [`CCSO_DATA_W-1:0]    data_reg;
    logic [`CCSO_DATA_W-1:0]    data_next;
    logic [`CCSO_BE_W-1:0]      be_reg;
    logic [`CCSO_BE_W-1:0]      be_next;
    logic                       last_reg;
    logic                       last_next;
    logic [`CCSO_KEEP_W-1:0]    keep_reg;
    logic [`CCSO_KEEP_W-1:0]    keep_next;
    logic                       ready;
    logic                       load;
    logic [`CCSO_BE_W-1:0]      lane_on;
    logic [`CCSO_BE_W-1:0]      pay_run;
    logic [`CCSO_DATA_W-1:0]    data_mask;

    // all ready bits equal, bit 0 stands for them
    assign ready = cpl_out_ready[0];

    generate
        for (genvar g = 0; g < `CCSO_BE_W; g++) begin : g_lane
            assign data_mask[g*`CCSO_BYTE_W +: `CCSO_BYTE_W] = {`CCSO_BYTE_W{lane_on[g]}};
        end
    endgenerate

    always_comb begin
        lane_on     = low_bytes(width_bytes(width_cfg));
        push_last   = src_valid_in && fifo_in_ready && src_last_in;
        may_release = in_pkt_reg || (lasts_reg != '0) || !fifo_in_ready;
        // output register refills only when empty or beat taken
        load        = !valid_reg || ready;
        fifo_pop    = load && fifo_out_valid && may_release;
        pop_last    = fifo_pop && fifo_out.last;
        lasts_next  = lasts_reg + `CCSO_LASTCNT_W'(push_last) - `CCSO_LASTCNT_W'(pop_last);
        // stay inside a packet until its last beat is loaded
        in_pkt_next = fifo_pop ? !fifo_out.last : in_pkt_reg;
        // payload lanes lo..hi form one run
        for (int i = 0; i < `CCSO_BE_W; i++) begin
            pay_run[i] = fifo_out.pay_en && (`CCSO_LANE_W'(i) >= fifo_out.pay_lo)
                         && (`CCSO_LANE_W'(i) <= fifo_out.pay_hi);
        end
        valid_next = valid_reg;
        data_next  = data_reg;
        be_next    = be_reg;
        last_next  = last_reg;
        keep_next  = keep_reg;
        if (load) begin
            // valid follows presence of a released beat
            valid_next = fifo_pop;
            if (fifo_pop) begin
                data_next = fifo_out.data & data_mask;
                // descriptor lanes carry no enables, width clipped
                be_next   = pay_run & lane_on;
                last_next = fifo_out.last;
                // full keep on all but the final beat
                keep_next = fifo_out.last ? low_dwords(fifo_out.dw_count) & low_dwords(width_dwords(width_cfg))
                                          : low_dwords(width_dwords(width_cfg));
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            valid_reg  <= 1'b0;
            data_reg   <= '0;
            be_reg     <= '0;
            last_reg   <= 1'b0;
            keep_reg   <= '0;
            lasts_reg  <= '0;
            in_pkt_reg <= 1'b0;
        end else begin
            valid_reg  <= valid_next;
            data_reg   <= data_next;
            be_reg     <= be_next;
            last_reg   <= last_next;
            keep_reg   <= keep_next;
            lasts_reg  <= lasts_next;
            in_pkt_reg <= in_pkt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; transfer is valid_reg and ready in the same cycle

    always_comb begin
        cpl_out_valid      = valid_reg;
        cpl_out_data       = data_reg;
        cpl_out_sideband   = {{(`CCSO_SIDE_W-`CCSO_BE_W){1'b0}}, be_reg};
        cpl_out_last_beat  = last_reg;
        cpl_out_dword_keep = keep_reg;
    end

endmodule : ccso_top

/* rtl/ccso_cfg.svh */
// Constants for the completion stream output block
`ifndef CCSO_CFG_SVH
`define CCSO_CFG_SVH

`define CCSO_DATA_W      256
`define CCSO_SIDE_W      75
`define CCSO_KEEP_W      8
`define CCSO_BE_W        32
`define CCSO_READY_W     22
`define CCSO_DWCNT_W     4
`define CCSO_LANE_W      5
`define CCSO_FIFO_DEPTH  16
`define CCSO_LASTCNT_W   5
`define CCSO_BYTES_64    6'h08
`define CCSO_BYTES_128   6'h10
`define CCSO_BYTES_256   6'h20
`define CCSO_DWORDS_64   4'h2
`define CCSO_DWORDS_128  4'h4
`define CCSO_DWORDS_256  4'h8
`define CCSO_BYTES_PER_DW 4
`define CCSO_BYTE_W      8

`endif

/* rtl/ccso_pkg.sv */
// Types shared by the completion stream output block
`include "ccso_cfg.svh"
package ccso_pkg;

    typedef enum logic [1:0] {
        CCSO_W64  = 2'b00,
        CCSO_W128 = 2'b01,
        CCSO_W256 = 2'b10
    } ccso_width_t;

    typedef struct packed {
        logic                        last;
        logic [`CCSO_DWCNT_W-1:0]    dw_count;
        logic                        pay_en;
        logic [`CCSO_LANE_W-1:0]     pay_lo;
        logic [`CCSO_LANE_W-1:0]     pay_hi;
        logic [`CCSO_DATA_W-1:0]     data;
    } ccso_entry_t;

endpackage : ccso_pkg

/* rtl/ccso_fifo.sv */
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module ccso_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      wr_ptr_next;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      rd_ptr_next;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Full when pointers differ only in the wrap bit
    always_comb begin
        empty         = (wr_ptr_reg == rd_ptr_reg);
        full          = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
        in_ready_out  = !full;
        out_valid_out = !empty;
        out_data_out  = mem[rd_ptr_reg[AW-1:0]];
        push          = in_valid_in && !full;
        pop           = out_ready_in && !empty;
        wr_ptr_next   = push ? wr_ptr_reg + (AW+1)'(1) : wr_ptr_reg;
        rd_ptr_next   = pop ? rd_ptr_reg + (AW+1)'(1) : rd_ptr_reg;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage carries no reset; only pointers define content
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
        end
    end

endmodule : ccso_fifo

/* tb/ccso_asserts.sv */
// Port-level checks for the completion stream output stage
`timescale 1ns/1ps
`include "ccso_cfg.svh"
module ccso_asserts (
    input wire logic                     clk_in,
    input wire logic                     reset_in,
    input wire logic [1:0]               bus_width_in,
    input wire logic                     cpl_out_valid,
    input wire logic [`CCSO_READY_W-1:0] cpl_out_ready,
    input wire logic [`CCSO_DATA_W-1:0]  cpl_out_data,
    input wire logic [`CCSO_SIDE_W-1:0]  cpl_out_sideband,
    input wire logic                     cpl_out_last_beat,
    input wire logic [`CCSO_KEEP_W-1:0]  cpl_out_dword_keep
);
    logic [31:0] be;
    logic [31:0] kb;
    assign be = cpl_out_sideband[31:0];
    always_comb begin
        for (int i = 0; i < 32; i++) kb[i] = cpl_out_dword_keep[i / 4];
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    hold_stall_a: assert property (cpl_out_valid && !cpl_out_ready[0] |=> cpl_out_valid
        && $stable(cpl_out_data) && $stable(cpl_out_sideband) && $stable(cpl_out_last_beat)
        && $stable(cpl_out_dword_keep)) else $error("Output moved while stalled");
    pkt_open_a: assert property (cpl_out_valid && cpl_out_ready[0] && !cpl_out_last_beat |=> cpl_out_valid)
        else $error("Valid dropped inside a packet");
    rst_idle_a: assert property (disable iff (1'b0) reset_in || $past(reset_in) |-> !cpl_out_valid)
        else $error("Valid high around reset");
    keep_run_a: assert property (cpl_out_valid |-> cpl_out_dword_keep[0]
        && ((cpl_out_dword_keep + 8'h01) & cpl_out_dword_keep) == 8'h00) else $error("Keep not contiguous");
    keep_full_a: assert property (cpl_out_valid && !cpl_out_last_beat |-> cpl_out_dword_keep inside
        {8'h03, 8'h0f, 8'hff}) else $error("Partial keep before last beat");
    be_run_a: assert property (cpl_out_valid |-> ((be + (be & (~be + 32'h1))) & be) == 32'h0)
        else $error("Byte enables have a gap");
    be_keep_a: assert property (cpl_out_valid |-> (be & ~kb) == 32'h0)
        else $error("Byte enable outside kept dwords");
    w128_zero_a: assert property ((bus_width_in == 2'b01)[*5] ##0 cpl_out_valid |-> be[31:16] == 16'h0
        && cpl_out_data[255:128] == 128'h0) else $error("Upper bits set at 128-bit width");
    w64_zero_a: assert property ((bus_width_in == 2'b00)[*5] ##0 cpl_out_valid |-> be[31:8] == 24'h0
        && cpl_out_data[255:64] == 192'h0) else $error("Upper bits set at 64-bit width");
endmodule : ccso_asserts
bind ccso_top ccso_asserts u_chk (.clk_in(clk_in), .reset_in(reset_in), .bus_width_in(bus_width_in),
    .cpl_out_valid(cpl_out_valid), .cpl_out_ready(cpl_out_ready), .cpl_out_data(cpl_out_data),
    .cpl_out_sideband(cpl_out_sideband), .cpl_out_last_beat(cpl_out_last_beat),
    .cpl_out_dword_keep(cpl_out_dword_keep));

/* tb/ccso_consumer.sv */
// Consumer model: paced ready and a log of accepted beats
`timescale 1ns/1ps
`include "ccso_cfg.svh"
module ccso_consumer (
    input  wire logic                     clk_in,
    input  wire logic                     reset_in,
    input  wire logic [1:0]               mode_in,
    input  wire logic                     cpl_valid_in,
    input  wire logic [`CCSO_DATA_W-1:0]  cpl_data_in,
    input  wire logic [31:0]              cpl_be_in,
    input  wire logic                     cpl_last_in,
    input  wire logic [`CCSO_KEEP_W-1:0]  cpl_keep_in,
    output logic [`CCSO_READY_W-1:0]      cpl_ready_out
);
    logic [`CCSO_DATA_W+40:0] beats[$];
    logic                     phase_reg;
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_reg <= 1'b0;
            cpl_ready_out <= 22'h0;
        end else begin
            if (cpl_valid_in && cpl_ready_out[0]) beats.push_back({cpl_last_in, cpl_keep_in, cpl_be_in, cpl_data_in});
            phase_reg <= ~phase_reg;
            cpl_ready_out <= {22{(mode_in == 2'b00) || (mode_in == 2'b01 && phase_reg)}};
        end
    end
endmodule : ccso_consumer

/* tb/completion_stream_out_handshake_tb.sv */
// Self-checking bench for the completion stream output stage
`timescale 1ns/1ps
`include "ccso_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module completion_stream_out_handshake_tb;
    logic         clk_in = 1'b0;
    logic         reset_in = 1'b1;
    logic [1:0]   bus_width = 2'b10;
    logic         src_valid = 1'b0;
    logic [255:0] src_data = 256'h0;
    logic         src_last = 1'b0;
    logic [3:0]   src_cnt = 4'h8;
    logic         src_pay_en = 1'b0;
    logic [4:0]   src_lo = 5'h00;
    logic [4:0]   src_hi = 5'h00;
    logic [1:0]   mode = 2'b00;
    logic         src_ready;
    logic         valid;
    logic [21:0]  ready;
    logic [255:0] data;
    logic [74:0]  side;
    logic         last;
    logic [7:0]   keep;
    int           mismatches = 0;
    int           n_checks = 0;
    always #5 clk_in = ~clk_in;
    ccso_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .bus_width_in(bus_width), .src_valid_in(src_valid),
        .src_ready_out(src_ready), .src_data_in(src_data), .src_last_in(src_last), .src_dw_count_in(src_cnt),
        .src_pay_en_in(src_pay_en), .src_pay_lo_in(src_lo), .src_pay_hi_in(src_hi), .cpl_out_valid(valid),
        .cpl_out_ready(ready), .cpl_out_data(data), .cpl_out_sideband(side), .cpl_out_last_beat(last),
        .cpl_out_dword_keep(keep));
    ccso_consumer u_cons (.clk_in(clk_in), .reset_in(reset_in), .mode_in(mode), .cpl_valid_in(valid),
        .cpl_data_in(data), .cpl_be_in(side[31:0]), .cpl_last_in(last), .cpl_keep_in(keep), .cpl_ready_out(ready));
    ////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    function automatic logic [31:0] be_of(input logic [4:0] lo, input logic [4:0] hi);
        be_of = (hi < lo) ? 32'h0 : ((32'hffffffff >> (31 - hi)) & (32'hffffffff << lo));
    endfunction : be_of
    // Valid stays up afterwards; recv lowers it, so no double drive in one step
    task automatic send(input logic [255:0] d, input logic l, input logic [3:0] c, input logic [4:0] lo,
                        input logic [4:0] hi, input int lim, output bit ok);
        bit r;
        src_valid <= 1'b1;
        src_data <= d;
        src_last <= l;
        src_cnt <= c;
        src_lo <= lo;
        src_hi <= hi;
        src_pay_en <= (hi >= lo);
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge clk_in);
            r = src_ready;
            @(posedge clk_in);
            ok = r;
        end
    endtask : send
    task automatic recv(input logic [255:0] d, input logic [31:0] be, input logic l, input logic [7:0] k);
        logic [296:0] b;
        src_valid <= 1'b0;
        for (int i = 0; i < 100 && u_cons.beats.size() == 0; i++) @(negedge clk_in);
        if (u_cons.beats.size() == 0) begin
            mismatches++;
            finish_test();
        end
        b = u_cons.beats.pop_front();
        `CHK(b, {l, k, be, d})
        @(posedge clk_in);
    endtask : recv
    ////////////////////////////////////////////////////////////////
    task automatic t_single;
        bit ok;
        for (int c = 1; c <= 8; c++) begin
            send({64{c[3:0]}}, 1'b1, c[3:0], 5'h04, 5'(4 * c - 1), 20, ok);
            `CHK(ok, 1'b1)
            recv({64{c[3:0]}}, be_of(5'h04, 5'(4 * c - 1)), 1'b1, 8'hff >> (8 - c));
        end
    endtask : t_single
    task automatic t_stall;
        bit ok;
        mode <= 2'b01;
        send({8{32'ha0}}, 1'b0, 4'h8, 5'h04, 5'h1f, 20, ok);
        `CHK(ok, 1'b1)
        send({8{32'ha1}}, 1'b0, 4'h8, 5'h00, 5'h1f, 20, ok);
        `CHK(ok, 1'b1)
        send({8{32'ha2}}, 1'b1, 4'h3, 5'h00, 5'h0b, 20, ok);
        `CHK(ok, 1'b1)
        recv({8{32'ha0}}, 32'hfffffff0, 1'b0, 8'hff);
        recv({8{32'ha1}}, 32'hffffffff, 1'b0, 8'hff);
        recv({8{32'ha2}}, 32'h00000fff, 1'b1, 8'h07);
        mode <= 2'b00;
    endtask : t_stall
    // Code 3 is expected to act as the widest bus
    task automatic t_width;
        bit           ok;
        logic [255:0] d;
        logic [31:0]  be;
        logic [7:0]   k;
        for (int w = 0; w < 4; w++) begin
            bus_width <= w[1:0];
            d  = (w == 0) ? {192'h0, {64{1'b1}}} : (w == 1) ? {128'h0, {128{1'b1}}} : {256{1'b1}};
            be = (w == 0) ? 32'h000000ff : (w == 1) ? 32'h0000ffff : 32'hffffffff;
            k  = (w == 0) ? 8'h03 : (w == 1) ? 8'h0f : 8'hff;
            repeat (6) @(posedge clk_in);
            send({256{1'b1}}, 1'b1, 4'h8, 5'h00, 5'h1f, 20, ok);
            `CHK(ok, 1'b1)
            recv(d, be, 1'b1, k);
        end
        bus_width <= 2'b10;
        repeat (6) @(posedge clk_in);
    endtask : t_width
    // Stalled consumer: buffer must fill and refuse, then drain in order
    task automatic t_fill;
        bit ok;
        int n;
        n = 0;
        ok = 1'b1;
        mode <= 2'b10;
        while (ok && n < 24) begin
            send(256'(n), 1'b0, 4'h8, 5'h00, 5'h1f, 3, ok);
            n = n + ok;
        end
        `CHK(n >= 16 && n <= 18, 1'b1)
        mode <= 2'b00;
        send(256'(n), 1'b1, 4'h8, 5'h00, 5'h1f, 20, ok);
        for (int k = 0; k <= n; k++) recv(256'(k), 32'hffffffff, k == n, 8'hff);
    endtask : t_fill
    // Reset in mid-run: a stalled beat is dropped and nothing follows release
    task automatic t_reset;
        bit ok;
        mode <= 2'b10;
        send(256'h5a, 1'b1, 4'h8, 5'h00, 5'h1f, 20, ok);
        `CHK(ok, 1'b1)
        src_valid <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(valid, 1'b1)
        @(posedge clk_in);
        reset_in <= 1'b1;
        mode <= 2'b00;
        @(negedge clk_in);
        `CHK(valid, 1'b0)
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        `CHK(u_cons.beats.size(), 0)
    endtask : t_reset
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        t_single();
        t_stall();
        t_width();
        t_fill();
        t_reset();
        repeat (5) @(posedge clk_in);
        `CHK(u_cons.beats.size(), 0)
        finish_test();
    end
endmodule : completion_stream_out_handshake_tb
